// *** src/adb_pkg.sv ***
// Shared constants and carrier types for the audio DC-block, volume and clipper path
package adb_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] A_CLIP_HI = 8'h01;
    localparam logic [7:0] A_FMT = 8'h02;
    localparam logic [7:0] A_RAMP = 8'h03;
    localparam logic [7:0] A_VOL = 8'h04;
    localparam logic [7:0] A_STAT = 8'h05;
    localparam logic [7:0] A_CLIP_MD = 8'h10;
    localparam logic [7:0] A_CLIP_LO = 8'h11;
    localparam logic [7:0] A_CORNER = 8'h13;
    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int BYP_BIT = 7;
    localparam int PACE_BIT = 6;
    localparam int CORN_HI = 7;
    localparam int CORN_LO = 5;
    localparam int VLSB_BIT = 0;
    localparam int GAIN_HI = 1;
    localparam int GAIN_LO = 0;
    localparam logic [8:0] VOL_RST = 9'h19e;
    localparam logic [8:0] VOL_MUTE = 9'h00e;
    localparam logic [19:0] CLIP_OFF = 20'hfffff;
    localparam logic [7:0] REG_ZERO = 8'h00;
    // ----------------------------------------------------------------
    // Arithmetic and timing constants
    // ----------------------------------------------------------------
    localparam int SW = 24;
    localparam int DCB_FRAC = 16;
    localparam int DCB_BASE = 11;
    localparam logic [2:0] SLOW_LAST = 3'h7;
    localparam logic [8:0] MANT_OFS = 9'h006;
    localparam logic [4:0] STEPS_OCT = 5'h18;
    localparam logic [4:0] OCT_REF = 5'h11;
    localparam int MANT_FRAC = 14;
    localparam int DC_SHIFT = 8;
    localparam logic [23:0] DC_THR = 24'h080000;
    localparam logic [15:0] MANT [24] = '{
        16'h4000, 16'h41e0, 16'h43cd, 16'h45c9, 16'h47d3, 16'h49ed, 16'h4c16, 16'h4e50,
        16'h509a, 16'h52f6, 16'h5562, 16'h57e1, 16'h5a83, 16'h5d28, 16'h5fe1, 16'h62af,
        16'h6592, 16'h688a, 16'h6b99, 16'h6ebe, 16'h71fb, 16'h7550, 16'h78be, 16'h7c46};
    // ----------------------------------------------------------------
    // Carrier types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic clipped;
        logic signed [SW-1:0] data;
    } adb_smp_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } adb_reg_req_t;
endpackage

// *** src/adb_skid_buf.sv ***
// Two-entry sample buffer between the processing path and the modulator
`timescale 1ns/1ps
module adb_skid_buf
(
    clk,
    rst,
    in_valid,
    in_ready,
    in_smp,
    out_valid,
    out_ready,
    out_smp
);
    input wire logic clk;
    input wire logic rst;
    input wire logic in_valid;
    output logic in_ready;
    input wire adb_pkg::adb_smp_t in_smp;
    output logic out_valid;
    input wire logic out_ready;
    output adb_pkg::adb_smp_t out_smp;
    import adb_pkg::*;

    adb_smp_t mem_q [2];
    logic wp_q;
    logic rp_q;
    logic [1:0] cnt_q;
    logic push;
    logic pop;

    // Honest full and empty straight from the occupancy count
    assign in_ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_smp = mem_q[rp_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage, written only on a push
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_q[wp_q] <= in_smp;
        end
    end

    // Pointers and count
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                wp_q <= ~wp_q;
            end
            if (pop)
            begin
                rp_q <= ~rp_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // Offered word must stand unchanged until the modulator takes it
    chk_buf_holds: assert property (@(posedge clk) disable iff (rst)
        out_valid && !out_ready |=> out_valid && $stable(out_smp))
        else $error("buffered word changed before taken");
endmodule

// *** src/adb_audio_path.sv ***
// Audio path: DC-block filter, ramped volume, saturation, clipper and DC fault
//
// Behaviour
// - Lasting DC at the output latches a fault and turns the power stage off.
// - Samples pass the DC-block filter; bit 7 of 0x02 bypasses it.
// - Filter corner is picked by corner_select, bits 7:5 of 0x13.
// - Each corner code doubles the cutoff; cutoff tracks the sample rate.
// - Two-bit gain code drives the analog gain selection of the amplifier.
// - Sample plus volume above full scale saturates in the digital domain.
// - Nine-bit volume code, 0x19E is 0 dB, quarter-dB per code.
// - Volume upper bits live in 0x04, its low bit in 0x13 bit 0.
// - Volume codes below 0x0E silence audio while switching continues.
// - Volume moves one code per frame or per eight frames, by bit 6 of 0x03.
// - Clipper keeps sample magnitude within the programmed limit_level times eight plus seven.
// - limit_level is assembled from registers 0x01, 0x10 and 0x11.
// - limit_level of 0xFFFFF leaves samples untouched.
`timescale 1ns/1ps
module adb_audio_path
(
    clk,
    rst,
    reg_req,
    reg_rdata,
    frame_clk,
    in_valid,
    in_ready,
    in_data,
    out_valid,
    out_ready,
    out_smp,
    fault_clr,
    dc_fault,
    power_stage_en,
    analog_gain
);
    input wire logic clk;
    input wire logic rst;
    input wire adb_pkg::adb_reg_req_t reg_req;
    output logic [7:0] reg_rdata;
    input wire logic frame_clk;
    input wire logic in_valid;
    output logic in_ready;
    input wire logic signed [adb_pkg::SW-1:0] in_data;
    output logic out_valid;
    input wire logic out_ready;
    output adb_pkg::adb_smp_t out_smp;
    input wire logic fault_clr;
    output logic dc_fault;
    output logic power_stage_en;
    output logic [1:0] analog_gain;
    import adb_pkg::*;

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    logic [7:0] clip_hi_q;
    logic [7:0] fmt_q;
    logic [7:0] ramp_q;
    logic [7:0] vol_q;
    logic [7:0] clip_md_q;
    logic [7:0] clip_lo_q;
    logic [7:0] corner_q;
    logic [7:0] rdata_q;
    logic [8:0] vol_tgt;
    logic [19:0] limit_level;
    logic [8:0] vol_cur_q;
    logic fault_q;

    // Host writes; an unknown offset is ignored
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            clip_hi_q <= CLIP_OFF[19:12];
            fmt_q <= REG_ZERO;
            ramp_q <= REG_ZERO;
            vol_q <= VOL_RST[8:1];
            clip_md_q <= CLIP_OFF[11:4];
            clip_lo_q <= {CLIP_OFF[3:0], 4'h0};
            corner_q <= {7'h00, VOL_RST[0]};
        end
        else if (reg_req.wr)
        begin
            if (reg_req.addr == A_CLIP_HI)
            begin
                clip_hi_q <= reg_req.wdata;
            end
            else if (reg_req.addr == A_FMT)
            begin
                fmt_q <= reg_req.wdata;
            end
            else if (reg_req.addr == A_RAMP)
            begin
                ramp_q <= reg_req.wdata;
            end
            else if (reg_req.addr == A_VOL)
            begin
                vol_q <= reg_req.wdata;
            end
            else if (reg_req.addr == A_CLIP_MD)
            begin
                clip_md_q <= reg_req.wdata;
            end
            else if (reg_req.addr == A_CLIP_LO)
            begin
                clip_lo_q <= reg_req.wdata;
            end
            else if (reg_req.addr == A_CORNER)
            begin
                corner_q <= reg_req.wdata;
            end
        end
    end

    // Read data is registered; unmapped offsets read zero
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rdata_q <= REG_ZERO;
        end
        else if (reg_req.rd)
        begin
            if (reg_req.addr == A_CLIP_HI)
            begin
                rdata_q <= clip_hi_q;
            end
            else if (reg_req.addr == A_FMT)
            begin
                rdata_q <= fmt_q;
            end
            else if (reg_req.addr == A_RAMP)
            begin
                rdata_q <= ramp_q;
            end
            else if (reg_req.addr == A_VOL)
            begin
                rdata_q <= vol_q;
            end
            else if (reg_req.addr == A_STAT)
            begin
                rdata_q <= {fault_q, 6'h00, vol_cur_q != vol_tgt};
            end
            else if (reg_req.addr == A_CLIP_MD)
            begin
                rdata_q <= clip_md_q;
            end
            else if (reg_req.addr == A_CLIP_LO)
            begin
                rdata_q <= clip_lo_q;
            end
            else if (reg_req.addr == A_CORNER)
            begin
                rdata_q <= corner_q;
            end
            else
            begin
                rdata_q <= REG_ZERO;
            end
        end
    end

    assign reg_rdata = rdata_q;
    assign vol_tgt = {vol_q, corner_q[VLSB_BIT]};
    assign limit_level = {clip_hi_q, clip_md_q, clip_lo_q[7:4]};
    assign analog_gain = ramp_q[GAIN_HI:GAIN_LO];

    // ----------------------------------------------------------------
    // Frame clock and volume ramp
    // ----------------------------------------------------------------
    logic fclk_m_q;
    logic fclk_s_q;
    logic fclk_d_q;
    logic frame_p;
    logic [2:0] fcnt_q;
    logic step_en;

    // Frame clock is a pin: two flops before any logic looks at it
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            fclk_m_q <= 1'b0;
            fclk_s_q <= 1'b0;
            fclk_d_q <= 1'b0;
        end
        else
        begin
            fclk_m_q <= frame_clk;
            fclk_s_q <= fclk_m_q;
            fclk_d_q <= fclk_s_q;
        end
    end

    assign frame_p = fclk_s_q && !fclk_d_q;

    // Frame divider for the slow pace
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            fcnt_q <= 3'h0;
        end
        else if (frame_p)
        begin
            fcnt_q <= (fcnt_q == SLOW_LAST) ? 3'h0 : fcnt_q + 3'h1;
        end
    end

    assign step_en = frame_p && (!ramp_q[PACE_BIT] || fcnt_q == SLOW_LAST);

    // One quarter-dB code per step toward the target
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            vol_cur_q <= VOL_RST;
        end
        else if (step_en && vol_cur_q < vol_tgt)
        begin
            vol_cur_q <= vol_cur_q + 9'h001;
        end
        else if (step_en && vol_cur_q > vol_tgt)
        begin
            vol_cur_q <= vol_cur_q - 9'h001;
        end
    end

    // ----------------------------------------------------------------
    // Sample processing
    // ----------------------------------------------------------------
    logic signed [39:0] dcb_q;
    logic signed [SW:0] dcb_y;
    logic signed [SW:0] stage1;
    logic [3:0] dcb_k;
    logic [4:0] oct;
    logic [4:0] frac;
    logic signed [47:0] prod;
    logic signed [47:0] scaled;
    logic signed [SW-1:0] sat;
    logic signed [SW-1:0] lim_pos;
    logic signed [SW-1:0] clip_out;
    logic clip_hit;
    logic mute;
    logic accept;
    adb_smp_t enq;

    // Cutoff is fs / (2*pi*2^k): one less shift doubles it, and it follows fs
    assign dcb_k = 4'(DCB_BASE) - {1'b0, corner_q[CORN_HI:CORN_LO]};
    // Estimate is read back signed, else a negative input would be zero-extended
    assign dcb_y = (SW+1)'(in_data) - (SW+1)'($signed(dcb_q[39:DCB_FRAC]));
    assign stage1 = fmt_q[BYP_BIT] ? (SW+1)'(in_data) : dcb_y;
    assign accept = in_valid && in_ready;

    // Running DC estimate, only moved by accepted samples
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            dcb_q <= 40'sh0;
        end
        else if (accept)
        begin
            dcb_q <= dcb_q + ((40'(dcb_y) <<< DCB_FRAC) >>> dcb_k);
        end
    end

    // Split the code into octave and quarter-dB step within the octave
    always_comb
    begin
        logic [8:0] r;
        r = vol_cur_q - MANT_OFS;
        oct = 5'h00;
        for (int i = 0; i < 21; i++)
        begin
            if (r >= {4'h0, STEPS_OCT})
            begin
                r = r - {4'h0, STEPS_OCT};
                oct = oct + 5'h01;
            end
        end
        frac = r[4:0];
    end

    // Gain is 2^((code - 0x19E)/24); wide product avoids overflow before saturation
    always_comb
    begin
        prod = 48'(stage1) * $signed({1'b0, MANT[frac]});
        if (oct >= OCT_REF)
        begin
            scaled = (prod <<< (oct - OCT_REF)) >>> MANT_FRAC;
        end
        else
        begin
            scaled = (prod >>> (OCT_REF - oct)) >>> MANT_FRAC;
        end
    end

    // Full-scale saturation; the spare headroom is deliberately not used
    always_comb
    begin
        if (scaled > 48'sh7fffff)
        begin
            sat = 24'sh7fffff;
        end
        else if (scaled < -48'sh800000)
        begin
            sat = -24'sh800000;
        end
        else
        begin
            sat = scaled[SW-1:0];
        end
    end

    assign mute = vol_cur_q < VOL_MUTE;
    assign lim_pos = {1'b0, limit_level, 3'h7};

    // Hard clipper on the magnitude; all ones disables it
    always_comb
    begin
        clip_out = sat;
        clip_hit = 1'b0;
        if (limit_level != CLIP_OFF)
        begin
            if (sat > lim_pos)
            begin
                clip_out = lim_pos;
                clip_hit = 1'b1;
            end
            else if (sat < -lim_pos)
            begin
                clip_out = -lim_pos;
                clip_hit = 1'b1;
            end
        end
    end

    assign enq.data = mute ? '0 : clip_out;
    assign enq.clipped = clip_hit && !mute;

    // Buffer absorbs a stalled modulator; its ready stalls the source
    adb_skid_buf u_buf
    (
        .clk(clk),
        .rst(rst),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_smp(enq),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_smp(out_smp)
    );

    // ----------------------------------------------------------------
    // DC detect fault
    // ----------------------------------------------------------------
    logic signed [31:0] dc_q;
    logic dc_high;

    // Slow average of what reaches the modulator
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            dc_q <= 32'sh0;
        end
        else if (accept)
        begin
            dc_q <= dc_q + ((32'(enq.data) - dc_q) >>> DC_SHIFT);
        end
    end

    // Threshold compared signed, so a small negative average is not mistaken for a huge one
    assign dc_high = dc_q > $signed(32'(DC_THR)) || dc_q < -$signed(32'(DC_THR));

    // Latching fault: a new detection wins over a clear in the same cycle
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            fault_q <= 1'b0;
        end
        else if (dc_high)
        begin
            fault_q <= 1'b1;
        end
        else if (fault_clr)
        begin
            fault_q <= 1'b0;
        end
    end

    assign dc_fault = fault_q;
    assign power_stage_en = !fault_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_detect;
        dc_high ##1 fault_q;
    endsequence

    chk_fault_sets: assert property (@(posedge clk) disable iff (rst)
        dc_high |-> s_detect)
        else $error("dc fault not latched");
    chk_fault_holds: assert property (@(posedge clk) disable iff (rst)
        fault_q && !fault_clr |=> fault_q && !power_stage_en)
        else $error("fault dropped without clear");
    chk_dcb_bypass: assert property (@(posedge clk) disable iff (rst)
        fmt_q[BYP_BIT] |-> stage1 == (SW+1)'(in_data))
        else $error("bypass not honoured");
    chk_clip_bound: assert property (@(posedge clk) disable iff (rst)
        accept && limit_level != CLIP_OFF |-> enq.data <= lim_pos && enq.data >= -lim_pos)
        else $error("sample beyond limit");
    chk_clip_off: assert property (@(posedge clk) disable iff (rst)
        accept && limit_level == CLIP_OFF && !mute |-> enq.data == sat)
        else $error("disabled clipper altered sample");
    chk_mute_zero: assert property (@(posedge clk) disable iff (rst)
        accept && vol_cur_q < VOL_MUTE |-> enq.data == '0 && power_stage_en == !fault_q)
        else $error("muted sample not zero");
    chk_unity_gain: assert property (@(posedge clk) disable iff (rst)
        vol_cur_q == VOL_RST && limit_level == CLIP_OFF |-> sat == stage1[SW-1:0] || stage1[SW] != stage1[SW-1])
        else $error("0 dB code not unity");
    chk_ramp_step: assert property (@(posedge clk) disable iff (rst)
        step_en && vol_cur_q != vol_tgt |=> vol_cur_q - $past(vol_cur_q) == 9'h001
            || $past(vol_cur_q) - vol_cur_q == 9'h001)
        else $error("volume step not one code");
    chk_ramp_hold: assert property (@(posedge clk) disable iff (rst)
        !step_en |=> $stable(vol_cur_q))
        else $error("volume moved between steps");
endmodule

// *** tb/adb_src_model.sv ***
// Sample source model: free-running frame clock and held sample handshake
`timescale 1ns/1ps
module adb_src_model
#(
    parameter int FRAME_HALF = 8
)
(
    clk,
    frame_clk,
    in_valid,
    in_ready,
    in_data
);
    import adb_pkg::*;
    input wire logic clk;
    output logic frame_clk;
    output logic in_valid;
    input wire logic in_ready;
    output logic signed [adb_pkg::SW-1:0] in_data;
    logic signed [SW-1:0] q [$];
    logic rdy_q;
    int fcnt;
    // Idle state at time zero
    initial
    begin
        frame_clk = 1'b0;
        in_valid = 1'b0;
        in_data = '0;
        rdy_q = 1'b0;
        fcnt = 0;
    end
    // Falling-edge launch keeps every level stable at the design's rising edge
    always @(negedge clk)
    begin
        fcnt = (fcnt + 1) % FRAME_HALF;
        if (fcnt == 0)
            frame_clk = ~frame_clk;
        if (in_valid && rdy_q)
            void'(q.pop_front());
        // Word held until taken; idle data toggles so no stale value looks valid
        in_valid = (q.size() != 0);
        in_data = in_valid ? q[0] : ~in_data;
        rdy_q = in_ready;
    end
endmodule

// *** tb/adb_audio_path_tb.sv ***
// Self-checking bench for the audio DC-block, volume and clipper path
`timescale 1ns/1ps
module adb_audio_path_tb;
    import adb_pkg::*;
    logic clk;
    logic rst;
    adb_reg_req_t reg_req;
    logic [7:0] reg_rdata;
    logic frame_clk;
    logic in_valid;
    logic in_ready;
    logic signed [SW-1:0] in_data;
    logic out_valid;
    logic out_ready;
    adb_smp_t out_smp;
    logic fault_clr;
    logic dc_fault;
    logic power_stage_en;
    logic [1:0] analog_gain;
    logic hold_out;
    adb_smp_t rxq [$];
    int fails = 0;
    int total_checks = 0;
    int cyc = 0;
    adb_audio_path u_adb_audio_path (.clk(clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .frame_clk(frame_clk), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
        .out_valid(out_valid), .out_ready(out_ready), .out_smp(out_smp), .fault_clr(fault_clr),
        .dc_fault(dc_fault), .power_stage_en(power_stage_en), .analog_gain(analog_gain));
    adb_src_model u_adb_src_model (.clk(clk), .frame_clk(frame_clk), .in_valid(in_valid),
        .in_ready(in_ready), .in_data(in_data));
    // ----------------------------------------------------------------
    // Clock, watchdog, sink and shared tasks
    // ----------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Runaway guard; the longest ramp needs under 10000 cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            fails++;
            print_verdict();
        end
    end
    // Modulator side; a word offered here is taken at the next rising edge
    always @(negedge clk)
    begin
        out_ready = !hold_out;
        if (out_valid && out_ready)
            rxq.push_back(out_smp);
    end
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        reg_req = '0;
    endtask
    // Read data is picked up a full cycle late; it stands until the next read
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk);
        reg_req = '0;
        @(negedge clk);
        d = reg_rdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        reg_rd(a, d);
        check({16'h0000, d}, {16'h0000, e});
    endtask
    // Polls the busy flag; returns the cycles it stayed up
    task automatic ramp_wait(output int n);
        logic [7:0] s;
        s = 8'h01;
        n = 0;
        while (s[0] && n < 9000)
        begin
            reg_rd(A_STAT, s);
            n += 3;
        end
        check({23'h0, s[0]}, 24'h000000);
    endtask
    task automatic pull(output adb_smp_t y);
        int n = 0;
        while (rxq.size() == 0 && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        check({23'h0, rxq.size() != 0}, 24'h000001);
        y = (rxq.size() != 0) ? rxq.pop_front() : '0;
    endtask
    task automatic xfer(input logic signed [SW-1:0] x, output adb_smp_t y);
        @(posedge clk);
        u_adb_src_model.q.push_back(x);
        pull(y);
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        logic [7:0] adr [7] = '{A_CLIP_HI, A_FMT, A_RAMP, A_VOL, A_CLIP_MD, A_CLIP_LO, A_CORNER};
        logic [7:0] val [7] = '{8'hff, 8'h00, 8'h00, 8'hcf, 8'hff, 8'hf0, 8'h00};
        int n;
        for (int i = 0; i < 7; i++)
            rd_chk(adr[i], val[i]);
        reg_wr(A_CLIP_MD, 8'h5a);
        rd_chk(A_CLIP_MD, 8'h5a);
        reg_wr(A_CLIP_MD, 8'hff);
        reg_wr(8'h07, 8'hff);
        rd_chk(8'h07, 8'h00);
        // Status must ignore the write; volume lsb cleared gives exactly 0 dB
        reg_wr(A_STAT, 8'hff);
        reg_wr(A_CORNER, 8'h00);
        ramp_wait(n);
        rd_chk(A_STAT, 8'h00);
    endtask
    task automatic t_gain();
        for (int i = 0; i < 4; i++)
        begin
            reg_wr(A_RAMP, 8'(i));
            check({22'h0, analog_gain}, 24'(i));
        end
        reg_wr(A_RAMP, 8'h00);
    endtask
    // Stalled sink: the buffer takes two words and refuses the third
    task automatic t_buffer();
        adb_smp_t y;
        reg_wr(A_FMT, 8'h80);
        @(posedge clk);
        hold_out = 1'b1;
        for (int i = 0; i < 3; i++)
            u_adb_src_model.q.push_back(24'sh000111 + i);
        repeat (8) @(negedge clk);
        check({23'h0, in_ready}, 24'h000000);
        check(24'(u_adb_src_model.q.size()), 24'h000001);
        @(posedge clk);
        hold_out = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            pull(y);
            check(y.data, 24'h000111 + i);
        end
    endtask
    task automatic t_clip();
        logic signed [SW-1:0] xi [4] = '{24'sh300000, 24'sh080008, 24'sh080007, 24'sh001234};
        logic signed [SW-1:0] xo [4] = '{24'sh080007, 24'sh080007, 24'sh080007, 24'sh001234};
        adb_smp_t y;
        reg_wr(A_CLIP_HI, 8'h10);
        reg_wr(A_CLIP_MD, 8'h00);
        reg_wr(A_CLIP_LO, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            xfer(xi[i], y);
            check(y.data, xo[i]);
            check({23'h0, y.clipped}, 24'(i < 2));
        end
        xfer(-24'sh300000, y);
        check({23'h0, y.data >= -24'sh080008}, 24'h000001);
        reg_wr(A_CLIP_HI, 8'hff);
        reg_wr(A_CLIP_MD, 8'hff);
        reg_wr(A_CLIP_LO, 8'hf0);
        xfer(24'sh7fffff, y);
        check(y.data, 24'h7fffff);
    endtask
    // Step input: lowest corner barely decays, highest corner removes it
    task automatic t_dcb();
        adb_smp_t y;
        logic signed [SW-1:0] slow;
        reg_wr(A_FMT, 8'h00);
        repeat (64) xfer(24'sh040000, y);
        slow = y.data;
        reg_wr(A_CORNER, 8'he0);
        repeat (64) xfer(24'sh040000, y);
        check({23'h0, slow > 24'sh030000}, 24'h000001);
        check({23'h0, y.data < 24'sh004000 && y.data > -24'sh004000}, 24'h000001);
        reg_wr(A_CORNER, 8'h00);
        reg_wr(A_FMT, 8'h80);
        xfer(24'sh040000, y);
        check(y.data, 24'h040000);
    endtask
    // Four quarter-dB steps, 16-cycle frames: fast about 64, slow about 512 cycles
    task automatic t_ramp();
        adb_smp_t y;
        int n;
        reg_wr(A_VOL, 8'hd1);
        ramp_wait(n);
        check({23'h0, n >= 45 && n <= 90}, 24'h000001);
        xfer(24'sh100000, y);
        check({23'h0, y.data > 24'sh118000 && y.data < 24'sh126000}, 24'h000001);
        xfer(24'sh7fffff, y);
        check(y.data, 24'h7fffff);
        reg_wr(A_RAMP, 8'h40);
        reg_wr(A_VOL, 8'hcf);
        ramp_wait(n);
        check({23'h0, n >= 370 && n <= 560}, 24'h000001);
        reg_wr(A_RAMP, 8'h00);
    endtask
    task automatic t_dc();
        adb_smp_t y;
        check({22'h0, dc_fault, power_stage_en}, 24'h000001);
        repeat (600) xfer(24'sh100000, y);
        check({22'h0, dc_fault, power_stage_en}, 24'h000002);
        rd_chk(A_STAT, 8'h80);
        repeat (400) xfer(24'sh000000, y);
        check({23'h0, dc_fault}, 24'h000001);
        @(negedge clk);
        fault_clr = 1'b1;
        @(negedge clk);
        fault_clr = 1'b0;
        @(negedge clk);
        check({22'h0, dc_fault, power_stage_en}, 24'h000001);
    endtask
    // Code 0x00d sits one below the lowest audible code
    task automatic t_mute();
        adb_smp_t y;
        int n;
        reg_wr(A_VOL, 8'h06);
        reg_wr(A_CORNER, 8'h01);
        ramp_wait(n);
        xfer(24'sh200000, y);
        check(y.data, 24'h000000);
        check({23'h0, power_stage_en}, 24'h000001);
    endtask
    initial
    begin
        rst = 1'b1;
        reg_req = '0;
        fault_clr = 1'b0;
        hold_out = 1'b0;
        // Four full rising edges under reset, released off the sampling edge
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_regs();
        t_gain();
        t_buffer();
        t_clip();
        t_dcb();
        t_ramp();
        t_dc();
        t_mute();
        print_verdict();
    end
endmodule
